// >>> src/ladder_pkg.sv
// shared constants and types of the ladder boolean block evaluator
`default_nettype none

package ladder_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int PA_W = 10;
  localparam int OPR_W = 12;
  localparam int STACK_DEPTH = 7;
  localparam int DEPTH_W = 3;
  localparam logic [PA_W-1:0] FIRST_ADDR = 10'h000;
  localparam logic [PA_W-1:0] LAST_ADDR = 10'h3FF;
  localparam logic [PA_W-1:0] ADDR_STEP = 10'h001;
  localparam logic [DEPTH_W-1:0] DEPTH_EMPTY = 3'h0;
  localparam logic [DEPTH_W-1:0] DEPTH_FULL = 3'h7;
  localparam logic [DEPTH_W-1:0] DEPTH_STEP = 3'h1;

  // ****************************************
  // instruction word
  // ****************************************
  typedef enum logic [3:0] {
    NO_OPERATION = 4'h0,
    LOAD_CONDITION_PUSH = 4'h1,
    LOAD_INVERTED_CONDITION_PUSH = 4'h2,
    SERIES_CONDITION = 4'h3,
    SERIES_INVERTED_CONDITION = 4'h4,
    PARALLEL_CONDITION = 4'h5,
    PARALLEL_INVERTED_CONDITION = 4'h6,
    BLOCK_CONJUNCTION_COMBINE = 4'h7,
    BLOCK_DISJUNCTION_COMBINE = 4'h8,
    DRIVE_BIT = 4'h9,
    DRIVE_BIT_INVERTED = 4'hA,
    PROGRAM_END = 4'hF
  } opcode_t;

  typedef struct packed {
    opcode_t op;
    logic [OPR_W-1:0] operand;
  } instr_t;

  // decoded controls of one instruction
  typedef struct packed {
    logic load;
    logic chain_and;
    logic chain_or;
    logic invert;
    logic blk_and;
    logic blk_or;
    logic drive;
    logic finish;
  } ctrl_t;

  // write of one bit of the io_relay_area
  typedef struct packed {
    logic we;
    logic [OPR_W-1:0] addr;
    logic value;
  } bit_write_t;

  typedef struct packed {
    logic underflow;
    logic overflow;
  } prog_err_t;

  localparam ctrl_t CTRL_IDLE = '0;
  localparam bit_write_t BIT_WRITE_IDLE = '0;
  localparam prog_err_t PROG_ERR_NONE = '0;

endpackage

`default_nettype wire

// >>> src/ladder_decoder.sv
// decoder from instruction word to evaluator controls
`default_nettype none

module ladder_decoder (
  input wire ladder_pkg::opcode_t op,
  output ladder_pkg::ctrl_t ctrl
);

  always_comb begin
    ctrl = ladder_pkg::CTRL_IDLE;
    unique case (op)
      ladder_pkg::LOAD_CONDITION_PUSH: begin
        ctrl.load = 1'b1;
      end
      ladder_pkg::LOAD_INVERTED_CONDITION_PUSH: begin
        ctrl.load = 1'b1;
        ctrl.invert = 1'b1;
      end
      ladder_pkg::SERIES_CONDITION: begin
        ctrl.chain_and = 1'b1;
      end
      ladder_pkg::SERIES_INVERTED_CONDITION: begin
        ctrl.chain_and = 1'b1;
        ctrl.invert = 1'b1;
      end
      ladder_pkg::PARALLEL_CONDITION: begin
        ctrl.chain_or = 1'b1;
      end
      ladder_pkg::PARALLEL_INVERTED_CONDITION: begin
        ctrl.chain_or = 1'b1;
        ctrl.invert = 1'b1;
      end
      // combines carry no operand
      ladder_pkg::BLOCK_CONJUNCTION_COMBINE: begin
        ctrl.blk_and = 1'b1;
      end
      ladder_pkg::BLOCK_DISJUNCTION_COMBINE: begin
        ctrl.blk_or = 1'b1;
      end
      // one word each, operand bit in the same word
      ladder_pkg::DRIVE_BIT: begin
        ctrl.drive = 1'b1;
      end
      ladder_pkg::DRIVE_BIT_INVERTED: begin
        ctrl.drive = 1'b1;
        ctrl.invert = 1'b1;
      end
      ladder_pkg::PROGRAM_END: begin
        ctrl.finish = 1'b1;
      end
      // unused codes execute as no operation
      default: begin
        ctrl = ladder_pkg::CTRL_IDLE;
      end
    endcase
  end

endmodule

`default_nettype wire

// >>> src/condition_stack.sv
// last-in-first-out store of saved execution conditions
`default_nettype none

module condition_stack (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic push,
  input wire logic pop,
  input wire logic push_bit,
  output logic top_bit,
  output logic [ladder_pkg::DEPTH_W-1:0] depth
);

  logic [ladder_pkg::STACK_DEPTH-1:0] mem_ff;
  logic [ladder_pkg::STACK_DEPTH-1:0] nxt_mem;
  logic [ladder_pkg::DEPTH_W-1:0] depth_ff;
  logic [ladder_pkg::DEPTH_W-1:0] nxt_depth;
  logic [ladder_pkg::DEPTH_W-1:0] top_idx;
  logic do_push;
  logic do_pop;

  // a push into a full store is dropped; the evaluator flags it
  assign do_push = push && !clear && (depth_ff != ladder_pkg::DEPTH_FULL);
  assign do_pop = pop && !clear && (depth_ff != ladder_pkg::DEPTH_EMPTY);
  assign top_idx = depth_ff - ladder_pkg::DEPTH_STEP;

  // newest entry sits just below the depth count
  assign top_bit = (depth_ff == ladder_pkg::DEPTH_EMPTY) ? 1'b0 :
                   mem_ff[top_idx];
  assign depth = depth_ff;

  genvar gi;
  generate
    for (gi = 0; gi < ladder_pkg::STACK_DEPTH; gi++) begin : g_entry
      always_comb begin
        nxt_mem[gi] = mem_ff[gi];
        if (do_push && (depth_ff == gi[ladder_pkg::DEPTH_W-1:0])) begin
          nxt_mem[gi] = push_bit;
        end
      end
    end
  endgenerate

  always_comb begin
    nxt_depth = depth_ff;
    if (clear) begin
      nxt_depth = ladder_pkg::DEPTH_EMPTY;
    end else if (do_push) begin
      nxt_depth = depth_ff + ladder_pkg::DEPTH_STEP;
    end else if (do_pop) begin
      nxt_depth = depth_ff - ladder_pkg::DEPTH_STEP;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_ff <= '0;
      depth_ff <= ladder_pkg::DEPTH_EMPTY;
    end else if (ce) begin
      mem_ff <= nxt_mem;
      depth_ff <= nxt_depth;
    end
  end

endmodule

`default_nettype wire

// >>> src/ladder_boolean_block_evaluator.sv
// boolean execution unit: scan control, condition logic, bit outputs
`default_nettype none

module ladder_boolean_block_evaluator (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic reload,
  output logic [ladder_pkg::PA_W-1:0] fetch_addr,
  input wire ladder_pkg::instr_t instr,
  output logic [ladder_pkg::OPR_W-1:0] operand_addr,
  input wire logic operand_value,
  output ladder_pkg::bit_write_t bit_write,
  output logic exec_cond,
  output logic scan_start,
  output logic running,
  output logic no_end,
  output ladder_pkg::prog_err_t prog_err,
  output logic [ladder_pkg::DEPTH_W-1:0] stack_depth
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {
    SEARCH,
    EXECUTE,
    HALTED
  } scan_state_t;

  scan_state_t state_ff;
  scan_state_t nxt_state;
  logic [ladder_pkg::PA_W-1:0] fetch_ff;
  logic [ladder_pkg::PA_W-1:0] nxt_fetch;
  logic cond_ff;
  logic nxt_cond;
  logic line_open_ff;
  logic nxt_line_open;
  logic scan_start_ff;
  logic nxt_scan_start;
  logic no_end_ff;
  logic nxt_no_end;
  ladder_pkg::bit_write_t bit_write_ff;
  ladder_pkg::bit_write_t nxt_bit_write;
  ladder_pkg::prog_err_t err_ff;
  ladder_pkg::prog_err_t nxt_err;
  logic running_ff;
  logic nxt_running;

  // ****************************************
  // decode and condition store
  // ****************************************
  ladder_pkg::ctrl_t ctrl;
  logic opnd_bit;
  logic stk_clear;
  logic stk_push;
  logic stk_pop;
  logic stk_top;
  logic [ladder_pkg::DEPTH_W-1:0] stk_depth;
  logic stk_empty;
  logic stk_full;
  logic executing;
  logic is_combine;
  logic combine_on_empty;
  logic push_on_full;

  ladder_decoder u_decoder (
    .op(instr.op),
    .ctrl(ctrl)
  );

  // only the running condition is ever saved, never an operand
  condition_stack u_stack (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .clear(stk_clear),
    .push(stk_push),
    .pop(stk_pop),
    .push_bit(cond_ff),
    .top_bit(stk_top),
    .depth(stk_depth)
  );

  // reload wins over execution in its own cycle
  assign executing = (state_ff == EXECUTE) && !reload;
  assign stk_empty = (stk_depth == ladder_pkg::DEPTH_EMPTY);
  assign stk_full = (stk_depth == ladder_pkg::DEPTH_FULL);
  assign is_combine = ctrl.blk_and || ctrl.blk_or;

  // operand bit is read back in the same cycle from the bit memory
  assign operand_addr = instr.operand;
  // inverted loads and chains fold into one xor on the operand bit
  assign opnd_bit = operand_value ^ ctrl.invert;

  // a load pushes only once a condition already stands on the line
  assign stk_push = executing && ctrl.load && line_open_ff;
  assign stk_pop = executing && (ctrl.blk_and || ctrl.blk_or) &&
                   !stk_empty;
  // store emptied on reload and at each new scan
  assign stk_clear = reload || (executing && ctrl.finish);

  // a combine with nothing saved, or a push past the last free entry
  assign combine_on_empty = is_combine && stk_empty;
  assign push_on_full = ctrl.load && line_open_ff && stk_full;

  // ****************************************
  // scan sequencing
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_fetch = fetch_ff;
    nxt_scan_start = 1'b0;
    nxt_no_end = no_end_ff;
    // the program store may have changed, so the search starts over
    if (reload) begin
      nxt_state = SEARCH;
      nxt_fetch = ladder_pkg::FIRST_ADDR;
      nxt_no_end = 1'b0;
    end else begin
      unique case (state_ff)
        // walk the store up to the first end word before running
        SEARCH: begin
          // an end word at the last address still wins over the halt
          if (ctrl.finish) begin
            nxt_state = EXECUTE;
            nxt_fetch = ladder_pkg::FIRST_ADDR;
            nxt_scan_start = 1'b1;
          end else if (fetch_ff == ladder_pkg::LAST_ADDR) begin
            nxt_state = HALTED;
            nxt_no_end = 1'b1;
          end else begin
            nxt_fetch = fetch_ff + ladder_pkg::ADDR_STEP;
          end
        end
        EXECUTE: begin
          // end taken whatever the condition; words after it never run
          if (ctrl.finish) begin
            nxt_fetch = ladder_pkg::FIRST_ADDR;
            nxt_scan_start = 1'b1;
          end else begin
            nxt_fetch = fetch_ff + ladder_pkg::ADDR_STEP;
          end
        end
        HALTED: begin
          nxt_state = HALTED;
        end
        // the unused state code falls back to a fresh search
        default: begin
          nxt_state = SEARCH;
          nxt_fetch = ladder_pkg::FIRST_ADDR;
        end
      endcase
    end
    // registered so the status pin never glitches on a state change
    nxt_running = (nxt_state == EXECUTE);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= SEARCH;
      fetch_ff <= ladder_pkg::FIRST_ADDR;
      scan_start_ff <= 1'b0;
      no_end_ff <= 1'b0;
      running_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      fetch_ff <= nxt_fetch;
      scan_start_ff <= nxt_scan_start;
      no_end_ff <= nxt_no_end;
      running_ff <= nxt_running;
    end
  end

  // ****************************************
  // execution condition
  // ****************************************
  // the condition is not cleared at scan start: the first load of each
  // scan sets it, so a program that drives before any load sees the
  // condition left by the previous scan
  always_comb begin
    nxt_cond = cond_ff;
    nxt_line_open = line_open_ff;
    if (reload) begin
      nxt_cond = 1'b0;
      nxt_line_open = 1'b0;
    end else if (executing) begin
      if (ctrl.load) begin
        nxt_cond = opnd_bit;
        nxt_line_open = 1'b1;
      end else if (ctrl.chain_and) begin
        nxt_cond = cond_ff & opnd_bit;
        nxt_line_open = 1'b1;
      end else if (ctrl.chain_or) begin
        nxt_cond = cond_ff | opnd_bit;
        nxt_line_open = 1'b1;
      end else if (ctrl.blk_and) begin
        // an empty store leaves the condition as it was
        if (!stk_empty) begin
          nxt_cond = cond_ff & stk_top;
        end
      end else if (ctrl.blk_or) begin
        if (!stk_empty) begin
          nxt_cond = cond_ff | stk_top;
        end
      end else if (ctrl.drive || ctrl.finish) begin
        // next load opens a fresh line; the condition stays for
        // further outputs sharing it
        nxt_line_open = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cond_ff <= 1'b0;
      line_open_ff <= 1'b0;
    end else if (ce) begin
      cond_ff <= nxt_cond;
      line_open_ff <= nxt_line_open;
    end
  end

  // ****************************************
  // bit outputs
  // ****************************************
  always_comb begin
    nxt_bit_write = ladder_pkg::BIT_WRITE_IDLE;
    if (executing && ctrl.drive) begin
      nxt_bit_write.we = 1'b1;
      nxt_bit_write.addr = instr.operand;
      nxt_bit_write.value = cond_ff ^ ctrl.invert;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_write_ff <= ladder_pkg::BIT_WRITE_IDLE;
    end else if (ce) begin
      bit_write_ff <= nxt_bit_write;
    end
  end

  // ****************************************
  // error flags
  // ****************************************
  // errors never stop the scan: the combine is skipped or the push
  // dropped, and the program runs on
  // sticky until reload; a new error in the reload cycle still lands
  always_comb begin
    nxt_err = reload ? ladder_pkg::PROG_ERR_NONE : err_ff;
    if (state_ff == EXECUTE) begin
      if (combine_on_empty) begin
        nxt_err.underflow = 1'b1;
      end
      if (push_on_full) begin
        nxt_err.overflow = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_ff <= ladder_pkg::PROG_ERR_NONE;
    end else if (ce) begin
      err_ff <= nxt_err;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign fetch_addr = fetch_ff;
  assign bit_write = bit_write_ff;
  assign exec_cond = cond_ff;
  assign scan_start = scan_start_ff;
  assign running = running_ff;
  assign no_end = no_end_ff;
  assign prog_err = err_ff;
  assign stack_depth = stk_depth;

endmodule

`default_nettype wire

// >>> verification/ladder_checker_properties.sv
// port assertions of the ladder boolean block evaluator
`default_nettype none

module ladder_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic reload,
  input wire logic [ladder_pkg::PA_W-1:0] fetch_addr,
  input wire ladder_pkg::instr_t instr,
  input wire logic [ladder_pkg::OPR_W-1:0] operand_addr,
  input wire logic operand_value,
  input wire ladder_pkg::bit_write_t bit_write,
  input wire logic exec_cond,
  input wire logic scan_start,
  input wire logic running,
  input wire logic no_end,
  input wire ladder_pkg::prog_err_t prog_err,
  input wire logic [ladder_pkg::DEPTH_W-1:0] stack_depth
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ex;
  ladder_pkg::opcode_t op;
  assign ex = running && ce && !reload;
  assign op = instr.op;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  drive_direct_a: assert property (
    ex && op == ladder_pkg::DRIVE_BIT |=> bit_write.we &&
    bit_write.value == $past(exec_cond) &&
    bit_write.addr == $past(instr.operand))
    else $error("direct drive wrong");
  drive_inverted_a: assert property (
    ex && op == ladder_pkg::DRIVE_BIT_INVERTED |=> bit_write.we &&
    bit_write.value == !$past(exec_cond))
    else $error("inverted drive wrong");
  end_restart_a: assert property (
    ex && op == ladder_pkg::PROGRAM_END |=> scan_start &&
    fetch_addr == ladder_pkg::FIRST_ADDR &&
    stack_depth == ladder_pkg::DEPTH_EMPTY)
    else $error("scan restart wrong");
  block_and_a: assert property (
    ex && op == ladder_pkg::BLOCK_CONJUNCTION_COMBINE &&
    stack_depth != ladder_pkg::DEPTH_EMPTY |=>
    stack_depth == $past(stack_depth) - ladder_pkg::DEPTH_STEP &&
    (!exec_cond || $past(exec_cond)))
    else $error("block and wrong");
  block_or_a: assert property (
    ex && op == ladder_pkg::BLOCK_DISJUNCTION_COMBINE &&
    stack_depth != ladder_pkg::DEPTH_EMPTY |=>
    stack_depth == $past(stack_depth) - ladder_pkg::DEPTH_STEP &&
    (exec_cond || !$past(exec_cond)))
    else $error("block or wrong");
  load_sets_a: assert property (
    ex && op == ladder_pkg::LOAD_CONDITION_PUSH |=>
    exec_cond == $past(operand_value))
    else $error("load wrong");
  series_and_a: assert property (
    ex && op == ladder_pkg::SERIES_CONDITION |=>
    exec_cond == ($past(exec_cond) && $past(operand_value)))
    else $error("series wrong");
  parallel_inv_a: assert property (
    ex && op == ladder_pkg::PARALLEL_INVERTED_CONDITION |=>
    exec_cond == ($past(exec_cond) || !$past(operand_value)))
    else $error("parallel inverted wrong");
  combine_underflow_a: assert property (
    ex && stack_depth == ladder_pkg::DEPTH_EMPTY &&
    (op == ladder_pkg::BLOCK_CONJUNCTION_COMBINE ||
    op == ladder_pkg::BLOCK_DISJUNCTION_COMBINE) |=>
    prog_err.underflow && exec_cond == $past(exec_cond))
    else $error("underflow not flagged");
  halted_silent_a: assert property (
    no_end |-> !running && !bit_write.we)
    else $error("runs without end word");
endmodule

bind ladder_boolean_block_evaluator ladder_checker ladder_checker_i (
  .clk(clk), .arst_n(arst_n), .ce(ce), .reload(reload),
  .fetch_addr(fetch_addr), .instr(instr), .operand_addr(operand_addr),
  .operand_value(operand_value), .bit_write(bit_write),
  .exec_cond(exec_cond), .scan_start(scan_start), .running(running),
  .no_end(no_end), .prog_err(prog_err), .stack_depth(stack_depth)
);

`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench of the ladder boolean block evaluator
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, ce, reload, operand_value, exec_cond;
  logic scan_start, running, no_end;
  logic [ladder_pkg::PA_W-1:0] fetch_addr;
  logic [ladder_pkg::OPR_W-1:0] operand_addr;
  logic [ladder_pkg::DEPTH_W-1:0] stack_depth, peak;
  ladder_pkg::instr_t instr;
  ladder_pkg::bit_write_t bit_write;
  ladder_pkg::prog_err_t prog_err;
  ladder_pkg::instr_t prog [0:1023];
  logic [7:0] b;
  logic wr_val [0:15];
  int wr_cnt [0:15];
  int fail_count, comparisons, pc, wr_total;

  // async-read program store and bit memory
  assign instr = prog[fetch_addr];
  assign operand_value = b[operand_addr[2:0]];

  ladder_boolean_block_evaluator ladder_boolean_block_evaluator_i (
    .clk(clk), .arst_n(arst_n), .ce(ce), .reload(reload),
    .fetch_addr(fetch_addr), .instr(instr), .operand_addr(operand_addr),
    .operand_value(operand_value), .bit_write(bit_write),
    .exec_cond(exec_cond), .scan_start(scan_start), .running(running),
    .no_end(no_end), .prog_err(prog_err), .stack_depth(stack_depth)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // records the pulse registered at the previous edge
  always @(posedge clk) begin
    if (bit_write.we === 1'b1) begin
      wr_val[bit_write.addr[3:0]] = bit_write.value;
      wr_cnt[bit_write.addr[3:0]]++;
      wr_total++;
    end
    if (stack_depth > peak) begin
      peak = stack_depth;
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic step();
    @(posedge clk);
    #5;
  endtask

  task automatic chk(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wait_start();
    int n;
    n = 0;
    do begin
      step();
      n++;
      if (n > 200) begin
        chk(1'b0, 1'b1, "no scan start");
        give_verdict();
      end
    end while (scan_start !== 1'b1);
  endtask

  task automatic put(input ladder_pkg::opcode_t op, input int opr);
    prog[pc] = {op, 12'(opr)};
    pc++;
  endtask

  // reload is held while the store is rewritten
  task automatic new_prog();
    reload = 1'b1;
    for (int i = 0; i < 1024; i++) begin
      prog[i] = '0;
    end
    pc = 0;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic no_end_halts();
    int n;
    n = 0;
    while (no_end !== 1'b1 && n < 1100) begin
      step();
      n++;
    end
    chk(no_end, 1'b1, "no end not found");
    chk(running, 1'b0, "running without end");
    chk(wr_total == 0, 1'b1, "write without end");
    chk(fetch_addr === ladder_pkg::LAST_ADDR, 1'b1, "search stop");
  endtask

  task automatic main_scan();
    logic s1;
    new_prog();
    put(ladder_pkg::LOAD_CONDITION_PUSH, 0);
    put(ladder_pkg::PARALLEL_CONDITION, 3);
    put(ladder_pkg::LOAD_CONDITION_PUSH, 1);
    put(ladder_pkg::LOAD_CONDITION_PUSH, 2);
    put(ladder_pkg::BLOCK_CONJUNCTION_COMBINE, 0);
    put(ladder_pkg::BLOCK_DISJUNCTION_COMBINE, 0);
    put(ladder_pkg::DRIVE_BIT, 1);
    put(ladder_pkg::DRIVE_BIT_INVERTED, 2);
    put(ladder_pkg::LOAD_INVERTED_CONDITION_PUSH, 0);
    put(ladder_pkg::SERIES_CONDITION, 1);
    put(ladder_pkg::SERIES_INVERTED_CONDITION, 2);
    put(ladder_pkg::PARALLEL_INVERTED_CONDITION, 3);
    put(ladder_pkg::DRIVE_BIT, 3);
    for (int k = 0; k < 8; k++) begin
      put(ladder_pkg::LOAD_CONDITION_PUSH, k);
    end
    for (int k = 0; k < 7; k++) begin
      put(ladder_pkg::BLOCK_CONJUNCTION_COMBINE, 0);
    end
    put(ladder_pkg::DRIVE_BIT, 4);
    put(ladder_pkg::LOAD_CONDITION_PUSH, 0);
    for (int k = 1; k < 10; k++) begin
      put(ladder_pkg::LOAD_CONDITION_PUSH, k % 8);
      put(ladder_pkg::BLOCK_DISJUNCTION_COMBINE, 0);
    end
    put(ladder_pkg::DRIVE_BIT, 5);
    put(ladder_pkg::NO_OPERATION, 0);
    put(ladder_pkg::PROGRAM_END, 0);
    put(ladder_pkg::DRIVE_BIT, 6);
    step();
    reload = 1'b0;
    for (int i = 0; i < 9; i++) begin
      b = (i == 8) ? 8'h00 : {5'h1F, 3'(i)};
      wait_start();
      wait_start();
      chk(fetch_addr === ladder_pkg::FIRST_ADDR, 1'b1, "restart");
      chk(stack_depth === ladder_pkg::DEPTH_EMPTY, 1'b1, "clear");
      step();
      s1 = b[0] | b[3] | (b[1] & b[2]);
      chk(wr_val[1], s1, "block combine");
      chk(wr_val[2], ~s1, "inverted drive");
      chk(wr_val[3], (~b[0] & b[1] & ~b[2]) | ~b[3], "chain");
      chk(wr_val[4], &b, "eight blocks");
      chk(wr_val[5], |b, "immediate combines");
    end
    chk(wr_cnt[6] == 0, 1'b1, "word after end ran");
    chk(peak === ladder_pkg::DEPTH_FULL, 1'b1, "depth peak");
    chk(prog_err === ladder_pkg::PROG_ERR_NONE, 1'b1, "false error");
  endtask

  // a frozen enable must hold the fetch position
  task automatic freeze_hold();
    logic [ladder_pkg::PA_W-1:0] a;
    a = fetch_addr;
    ce = 1'b0;
    repeat (5) step();
    chk(fetch_addr === a, 1'b1, "moved while frozen");
    ce = 1'b1;
  endtask

  task automatic error_flags();
    new_prog();
    put(ladder_pkg::LOAD_CONDITION_PUSH, 0);
    put(ladder_pkg::BLOCK_CONJUNCTION_COMBINE, 0);
    for (int k = 0; k < 9; k++) begin
      put(ladder_pkg::LOAD_CONDITION_PUSH, 0);
    end
    put(ladder_pkg::PROGRAM_END, 0);
    step();
    reload = 1'b0;
    wait_start();
    wait_start();
    chk(prog_err.underflow, 1'b1, "underflow flag");
    chk(prog_err.overflow, 1'b1, "overflow flag");
  endtask

  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    reload = 1'b0;
    b = 8'h00;
    peak = '0;
    fail_count = 0;
    comparisons = 0;
    wr_total = 0;
    pc = 0;
    for (int i = 0; i < 16; i++) begin
      wr_cnt[i] = 0;
      wr_val[i] = 1'bx;
    end
    for (int i = 0; i < 1024; i++) begin
      prog[i] = '0;
    end
    repeat (10) step();
    arst_n = 1'b1;
    no_end_halts();
    main_scan();
    freeze_hold();
    error_flags();
    give_verdict();
  end
endmodule

`default_nettype wire
